/* File: codec_model.sv */
// Codec model: external bit clock and frame sync for slave-mode runs
module codec_model (
   input wire logic ref_clk_i,
   input wire logic run_i,
   output logic sck_o = 1'b0,
   output logic fs_o = 1'b0,
   output logic sdi_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] half_q = 3'h0;
   logic [2:0] bit_q = 3'h0;

   // Data back to the engine is silence
   assign sdi_o = 1'b0;

   // Bit clock of 5-cycle halves, still while idle; sync high one bit in eight
   always @(posedge ref_clk_i) begin
      if (!run_i) begin
         half_q <= 3'h0;
         bit_q <= 3'h0;
         sck_o <= 1'b0;
         fs_o <= 1'b0;
      end else if (half_q == 3'h4) begin
         half_q <= 3'h0;
         sck_o <= ~sck_o;
         if (!sck_o) begin
            bit_q <= bit_q + 3'h1;
            fs_o <= (bit_q == 3'h0);
         end
      end else begin
         half_q <= half_q + 3'h1;
      end
   end
endmodule // codec_model

/* File: serial_frame_consts.svh */
// Register offsets, field positions, reset values and fixed frame counts of the framing engine
`ifndef SERIAL_FRAME_CONSTS_SVH
`define SERIAL_FRAME_CONSTS_SVH

// Register indices on the plain register port
`define REG_CTRL_ONE 4'h0
`define REG_CTRL_TWO 4'h1
`define REG_CTRL_THREE 4'h2
`define REG_TX_SLOTS 4'h3
`define REG_TX_WORD0 4'h4
`define REG_TX_WORD3 4'h7
`define REG_STATUS 4'h8

// Field positions in port_control_one
`define C1_ENABLE 0
`define C1_FS_DIR 1
`define C1_MODE_LO 2
`define C1_MODE_HI 3
`define C1_SCK_DIR 4
`define C1_EDGE 5
`define C1_JUSTIFY 6
`define C1_SDO_MODE 7

// Field positions in port_control_two
`define C2_WS_LO 0
`define C2_WS_HI 3
`define C2_FL_LO 4
`define C2_FL_HI 7

// Reset values
`define RST_CTRL_ONE 8'h00
`define RST_CTRL_TWO 8'h00
`define RST_CTRL_THREE 12'h000
`define RST_TX_SLOTS 16'h0000

// Pin indices of the four serial pins
`define PIN_SCK 0
`define PIN_SDO 1
`define PIN_SDI 2
`define PIN_FS 3

// Fixed AC-Link figures
`define AC_HEAD_BITS 8'h10
`define AC_FRAME_LAST 8'hFF
`define AC_TAG_LAST 5'h0F
`define AC_SLOT20_LAST 5'h13
`define AC16_WORD_LAST 4'hF
`define AC20_WORD_LAST 4'hC

`endif

/* File: serial_frame_engine.sv */
// Serial framing engine: bit clock, frame sync, slot counting and transmit shifting
`include "serial_frame_consts.svh"

module serial_frame_engine
   import serial_frame_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic [3:0] pin_i,
   output logic [3:0] pin_o,
   output logic [3:0] pin_oe_o,
   input wire logic [3:0] gp_o_i,
   input wire logic [3:0] gp_oe_i
);

   logic [7:0] ctrl1_q;
   logic [7:0] ctrl2_q;
   logic [11:0] bcg_q;
   logic [15:0] tse_q;
   logic en;
   logic fs_dir;
   logic sck_dir;
   logic edge_sel;
   logic early_data_justify_bit;
   logic sdom;
   fs_mode_t mode;
   logic [3:0] ws;
   logic [3:0] flen;
   logic sck_m_q, sck_s_q, sck_p_q;
   logic fs_m_q, fs_s_q, fs_prev_q;
   logic sdi_m_q, sdi_s_q;
   logic [11:0] div_q;
   logic sck_int_q;
   logic gen_on;
   logic rise_e, fall_e, drive_e, samp_e;
   logic [4:0] wl_last;
   logic [3:0] w_last;
   logic [8:0] total;
   logic [7:0] fend;
   logic [7:0] half;
   logic [7:0] fbit_q, fbit_nx;
   logic mst_run_q;
   logic fs_q;
   logic fs_nx;
   logic mst_go, slv_go, load;
   logic req_q, arm_q, trig, fin;
   eng_state_t state_q;
   logic [4:0] bit_q;
   logic [3:0] word_q;
   logic [1:0] ptr_q;
   logic [15:0] shift_q;
   logic sdo_q, sdo_oe_q;
   logic [15:0] mem_rdata, mem_bus_rdata;
   logic rd_mem_q;
   logic [15:0] rd_reg_q;

   assign en = ctrl1_q[`C1_ENABLE];
   assign fs_dir = ctrl1_q[`C1_FS_DIR];
   assign mode = fs_mode_t'(ctrl1_q[`C1_MODE_HI:`C1_MODE_LO]);
   assign sck_dir = ctrl1_q[`C1_SCK_DIR];
   assign edge_sel = ctrl1_q[`C1_EDGE];
   assign early_data_justify_bit = ctrl1_q[`C1_JUSTIFY];
   assign sdom = ctrl1_q[`C1_SDO_MODE];
   assign ws = ctrl2_q[`C2_WS_HI:`C2_WS_LO];
   assign flen = ctrl2_q[`C2_FL_HI:`C2_FL_LO];

   // Control register writes
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ctrl1_q <= `RST_CTRL_ONE;
         ctrl2_q <= `RST_CTRL_TWO;
         bcg_q <= `RST_CTRL_THREE;
         tse_q <= `RST_TX_SLOTS;
      end else if (wr_i) begin
         unique case (addr_i)
            `REG_CTRL_ONE: ctrl1_q <= wdata_i[7:0];
            `REG_CTRL_TWO: ctrl2_q <= wdata_i[7:0];
            `REG_CTRL_THREE: bcg_q <= wdata_i[11:0];
            `REG_TX_SLOTS: tse_q <= wdata_i;
            default: ;
         endcase
      end
   end

   // Register reads, answer one cycle later; unmapped reads return zero
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rd_reg_q <= 16'h0000;
         rd_mem_q <= 1'b0;
      end else begin
         rd_mem_q <= rd_i && addr_i >= `REG_TX_WORD0 && addr_i <= `REG_TX_WORD3;
         if (rd_i) begin
            unique case (addr_i)
               `REG_CTRL_ONE: rd_reg_q <= {8'h00, ctrl1_q};
               `REG_CTRL_TWO: rd_reg_q <= {8'h00, ctrl2_q};
               `REG_CTRL_THREE: rd_reg_q <= {4'h0, bcg_q};
               `REG_TX_SLOTS: rd_reg_q <= tse_q;
               `REG_STATUS: rd_reg_q <= {3'h0, sdi_s_q, state_q, ptr_q, word_q, bit_q};
               default: rd_reg_q <= 16'h0000;
            endcase
         end
      end
   end

   assign rdata_o = rd_mem_q ? mem_bus_rdata : rd_reg_q;

   // Shadow words, written by software, read by the slot loader
   tx_shadow_mem u_shadow (
      .ref_clk_i(ref_clk_i),
      .wr_i(wr_i && addr_i >= `REG_TX_WORD0 && addr_i <= `REG_TX_WORD3),
      .wr_addr_i(addr_i[1:0]),
      .wr_data_i(wdata_i),
      .eng_addr_i(ptr_q),
      .eng_data_o(mem_rdata),
      .bus_addr_i(addr_i[1:0]),
      .bus_data_o(mem_bus_rdata)
   );

   // Pin synchronisers; edges come from the second and third stage only
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         {sck_m_q, sck_s_q, sck_p_q} <= 3'h0;
         {fs_m_q, fs_s_q, sdi_m_q, sdi_s_q} <= 4'h0;
      end else begin
         sck_m_q <= pin_i[`PIN_SCK];
         sck_s_q <= sck_m_q;
         sck_p_q <= sck_s_q;
         fs_m_q <= pin_i[`PIN_FS];
         fs_s_q <= fs_m_q;
         sdi_m_q <= pin_i[`PIN_SDI];
         sdi_s_q <= sdi_m_q;
      end
   end

   // Bit clock divider, independent of the enable so the pin can run alone
   assign gen_on = !sck_dir && bcg_q != 12'h000;
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !gen_on) begin
         div_q <= 12'h000;
         sck_int_q <= 1'b0;
      end else if (div_q >= bcg_q) begin
         div_q <= 12'h000;
         sck_int_q <= ~sck_int_q;
      end else begin
         div_q <= div_q + 12'h001;
      end
   end

   // Bit clock edge events from the selected source
   always_comb begin
      if (sck_dir) begin
         rise_e = sck_s_q && !sck_p_q;
         fall_e = !sck_s_q && sck_p_q;
      end else begin
         rise_e = gen_on && div_q >= bcg_q && !sck_int_q;
         fall_e = gen_on && div_q >= bcg_q && sck_int_q;
      end
   end

   // Sampling edge per edge select; data change on the other edge
   assign samp_e = en && (edge_sel ? rise_e : fall_e);
   assign drive_e = en && (edge_sel ? fall_e : rise_e);

   // Word length and frame length per mode
   always_comb begin
      total = 9'(({5'h00, ws} + 9'h001) * ({5'h00, flen} + 9'h001));
      unique case (mode)
         FSM_MULTI, FSM_I2S: begin
            wl_last = {1'b0, ws};
            w_last = flen;
            fend = 8'(total - 9'h001);
         end
         FSM_AC16: begin
            wl_last = `AC_TAG_LAST;
            w_last = `AC16_WORD_LAST;
            fend = `AC_FRAME_LAST;
         end
         FSM_AC20: begin
            wl_last = (word_q == 4'h0) ? `AC_TAG_LAST : `AC_SLOT20_LAST;
            w_last = `AC20_WORD_LAST;
            fend = `AC_FRAME_LAST;
         end
      endcase
      half = total[8:1];
   end

   // Master frame bit counter and the sync level it implies
   always_comb begin
      fbit_nx = (!mst_run_q || fbit_q == fend) ? 8'h00 : fbit_q + 8'h01;
      unique case (mode)
         FSM_MULTI: fs_nx = fbit_nx == 8'h00;
         FSM_I2S: fs_nx = fbit_nx >= half;
         FSM_AC16, FSM_AC20: fs_nx = fbit_nx < `AC_HEAD_BITS;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !en || fs_dir) begin
         fbit_q <= 8'h00;
         mst_run_q <= 1'b0;
         fs_q <= 1'b0;
      end else if (drive_e) begin
         mst_run_q <= 1'b1;
         fbit_q <= fbit_nx;
         fs_q <= fs_nx;
      end
   end

   assign mst_go = drive_e && !fs_dir && fbit_nx == 8'h00;

   // Slave sync detection; ignored while a frame is under way, except in its last bit
   assign fin = state_q == ST_RUN && bit_q == wl_last && word_q == w_last;
   assign trig = samp_e && fs_dir && !req_q && !arm_q && (state_q == ST_IDLE || fin)
      && (mode == FSM_I2S ? fs_s_q != fs_prev_q : fs_s_q);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !en) begin
         req_q <= 1'b0;
         fs_prev_q <= 1'b0;
      end else begin
         if (samp_e) begin
            fs_prev_q <= fs_s_q;
         end
         if (trig) begin
            req_q <= 1'b1;
         end else if (drive_e) begin
            req_q <= 1'b0;
         end
      end
   end

   assign slv_go = drive_e && req_q;
   assign load = arm_q || slv_go || (mst_go && early_data_justify_bit);

   // Slot engine: start, shift, slot loads and pointer
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !en) begin
         state_q <= ST_IDLE;
         arm_q <= 1'b0;
         bit_q <= 5'h00;
         word_q <= 4'h0;
         ptr_q <= 2'h0;
         shift_q <= 16'h0000;
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else if (drive_e) begin
         arm_q <= mst_go && !early_data_justify_bit;
         if (load) begin
            state_q <= ST_RUN;
            bit_q <= 5'h00;
            word_q <= 4'h0;
            if (tse_q[0]) begin
               shift_q <= mem_rdata;
               sdo_q <= mem_rdata[15];
               sdo_oe_q <= 1'b1;
               ptr_q <= ptr_q + 2'h1;
            end else begin
               shift_q <= 16'h0000;
               sdo_q <= 1'b0;
               sdo_oe_q <= !sdom;
            end
         end else if (state_q == ST_RUN) begin
            if (bit_q == wl_last) begin
               bit_q <= 5'h00;
               if (word_q == w_last) begin
                  state_q <= ST_IDLE;
                  sdo_q <= 1'b0;
                  sdo_oe_q <= !sdom;
               end else begin
                  word_q <= word_q + 4'h1;
                  if (tse_q[word_q + 4'h1]) begin
                     shift_q <= mem_rdata;
                     sdo_q <= mem_rdata[15];
                     sdo_oe_q <= 1'b1;
                     ptr_q <= ptr_q + 2'h1;
                  end else begin
                     shift_q <= 16'h0000;
                     sdo_q <= 1'b0;
                     sdo_oe_q <= !sdom;
                  end
               end
            end else begin
               bit_q <= bit_q + 5'h01;
               shift_q <= {shift_q[14:0], 1'b0};
               sdo_q <= shift_q[14];
            end
         end else begin
            sdo_oe_q <= !sdom;
         end
      end
   end

   // Pin ownership: engine pins while enabled, bit clock pin also while its generator runs; general port otherwise
   always_comb begin
      pin_o = gp_o_i;
      pin_oe_o = gp_oe_i;
      if (en || gen_on) begin
         pin_o[`PIN_SCK] = sck_int_q;
         pin_oe_o[`PIN_SCK] = !sck_dir;
      end
      if (en) begin
         pin_o[`PIN_SDO] = sdo_q;
         pin_oe_o[`PIN_SDO] = sdo_oe_q;
         pin_o[`PIN_SDI] = 1'b0;
         pin_oe_o[`PIN_SDI] = 1'b0;
         pin_o[`PIN_FS] = fs_q;
         pin_oe_o[`PIN_FS] = !fs_dir;
      end
   end

   // Checks
   dis_reset_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !en |=> state_q == ST_IDLE && ptr_q == 2'h0 && word_q == 4'h0 && fbit_q == 8'h00)
      else $error("disabled engine kept counter state");
   pin_own_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      en |-> pin_oe_o[`PIN_SDI] == 1'b0 && pin_o[`PIN_FS] == fs_q && pin_o[`PIN_SDO] == sdo_q)
      else $error("enabled engine lost pin ownership");
   sck_alone_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !en && gen_on |-> pin_oe_o[`PIN_SCK] && pin_o[`PIN_SCK] == sck_int_q)
      else $error("bit clock not driven while engine disabled");
   word_wrap_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      en && drive_e && state_q == ST_RUN && !load && mode == FSM_MULTI
      && bit_q == ws && word_q != flen |=> bit_q == 5'h00 && word_q == $past(word_q) + 4'h1)
      else $error("word did not end after word size bits");
   frame_wrap_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      en && !fs_dir && drive_e && mst_run_q && fbit_q == fend |-> mst_go ##1 fbit_q == 8'h00)
      else $error("master frame counter did not wrap");
   ac_sync_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      en && !fs_dir && mst_run_q && mode[1] |-> fs_q == (fbit_q < `AC_HEAD_BITS))
      else $error("AC-Link sync shape wrong");
   multi_pulse_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      en && !fs_dir && mst_run_q && mode == FSM_MULTI |-> fs_q == (fbit_q == 8'h00))
      else $error("multi-channel sync pulse wrong");
   i2s_duty_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      en && !fs_dir && mst_run_q && mode == FSM_I2S |-> fs_q == (fbit_q >= half))
      else $error("I2S sync duty wrong");
   busy_ignore_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      state_q == ST_RUN && !fin |-> !trig)
      else $error("sync accepted during a running frame");
   div_toggle_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      gen_on && div_q == bcg_q && $stable(bcg_q) |=> sck_int_q != $past(sck_int_q))
      else $error("bit clock did not toggle at divider end");
   unused_slot_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      en && drive_e && (load ? !tse_q[0] : state_q == ST_RUN && bit_q == wl_last && !fin
      && !tse_q[word_q + 4'h1]) |=> !sdo_q && sdo_oe_q == !sdom)
      else $error("disabled slot drive wrong");

endmodule // serial_frame_engine

/* File: serial_frame_pkg.sv */
// Types shared by the framing engine files
package serial_frame_pkg;

   typedef enum logic [1:0] {
      FSM_MULTI = 2'b00,
      FSM_I2S = 2'b01,
      FSM_AC16 = 2'b10,
      FSM_AC20 = 2'b11
   } fs_mode_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } eng_state_t;

endpackage

/* File: testbench.sv */
// Testbench for the serial framing engine: register access and framing runs
`include "serial_frame_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic run_m = 1'b0;
   logic [3:0] gp_o_i = 4'hA;
   logic [3:0] gp_oe_i = 4'h5;
   logic [15:0] rdata_o;
   logic [3:0] pin_i, pin_o, pin_oe_o;
   logic sck_m, fs_m, sdi_m;
   logic fs_s [0:599];
   logic sd_s [0:599];
   logic oe_s [0:599];
   logic [15:0] words [0:3] = '{16'hA123, 16'h5FFF, 16'hC000, 16'h3000};
   int n_errors = 0;
   int num_checks = 0;

   // Clock at 100 MHz
   always #5 ref_clk_i = ~ref_clk_i;

   // Wire levels: a released pin shows the far side, released data its inverse
   assign pin_i[0] = pin_oe_o[0] ? pin_o[0] : sck_m;
   assign pin_i[1] = pin_oe_o[1] ? pin_o[1] : ~pin_o[1];
   assign pin_i[2] = sdi_m;
   assign pin_i[3] = pin_oe_o[3] ? pin_o[3] : fs_m;

   serial_frame_engine uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe_o(pin_oe_o), .gp_o_i(gp_o_i), .gp_oe_i(gp_oe_i));

   codec_model partner (.ref_clk_i(ref_clk_i), .run_i(run_m), .sck_o(sck_m),
      .fs_o(fs_m), .sdi_o(sdi_m));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   // Record sync, data and data enable at n bit clock edges of the chosen kind
   task automatic cap(input int n, input logic rise);
      int t;
      logic last, now, hit;
      last = pin_i[0];
      for (int k = 0; k < n; k++) begin
         t = 0;
         do begin
            @(posedge ref_clk_i);
            now = pin_i[0];
            t++;
            hit = (last !== now) && (now === rise);
            last = now;
         end while (!hit && t < 100);
         if (!hit) check(16'h0000, 16'h0001);
         fs_s[k] = pin_i[3];
         sd_s[k] = pin_o[1];
         oe_s[k] = pin_oe_o[1];
      end
   endtask

   function automatic int first_rise();
      for (int k = 1; k < 600; k++) begin
         if (fs_s[k] === 1'b1 && fs_s[k - 1] === 1'b0) return k;
      end
      return 0;
   endfunction

   // Disable the engine and see its counters cleared
   task automatic off();
      logic [15:0] v;
      wr(`REG_CTRL_ONE, 16'h0000);
      rd(`REG_STATUS, v);
      check(v & 16'h0FFF, 16'h0000);
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog against a hung handshake or a dead bit clock
   initial begin
      #200000;
      n_errors++;
      $display("ERROR %0t: timeout", $time);
      report_and_stop();
   end

   // Test sequence
   initial begin
      time t0;
      int s;
      int j;
      int f;
      logic [15:0] v;
      repeat (6) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      for (int a = 0; a < 4; a++) begin
         rd(4'(a), v);
         check(v, 16'h0000);
      end
      wr(4'h9, 16'hFFFF);
      rd(4'h9, v);
      check(v, 16'h0000);
      check(16'(pin_o), 16'(gp_o_i));
      check(16'(pin_oe_o), 16'(gp_oe_i));
      for (int a = 0; a < 4; a++) wr(`REG_TX_WORD0 + 4'(a), words[a]);
      wr(`REG_TX_SLOTS, 16'hFFFD);
      rd(`REG_TX_SLOTS, v);
      check(v, 16'hFFFD);
      rd(`REG_TX_WORD0 + 4'h1, v);
      check(v, 16'h5FFF);
      $display("register test done");
      wr(`REG_CTRL_THREE, 16'h0002);
      cap(1, 1'b1);
      t0 = $time;
      cap(1, 1'b1);
      check(16'(($time - t0) / 10), 16'h0006);
      check(16'(pin_oe_o[0]), 16'h0001);
      $display("bit clock test done");
      // Master multi-channel: 4-bit words, 2 slots, slot 1 released
      wr(`REG_CTRL_TWO, 16'h0013);
      wr(`REG_CTRL_ONE, 16'h0081);
      check(16'(pin_oe_o[3:2]), 16'h0002);
      cap(32, 1'b0);
      s = first_rise();
      for (int i = 0; i < 16; i++) begin
         j = i % 8;
         // Frame index picks the shadow word, since the pointer wraps freely
         f = (s / 8 + i / 8) % 4;
         check(16'(fs_s[s + i]), 16'(j == 0));
         if (j < 4) check(16'(sd_s[s + 1 + i]), 16'(words[f][15 - j]));
         else check(16'(oe_s[s + 1 + i]), 16'h0000);
      end
      $display("master multi-channel test done");
      // I2S master sampled on rising edges, from a fresh enable
      off();
      wr(`REG_CTRL_ONE, 16'h0025);
      cap(32, 1'b1);
      s = first_rise();
      for (int i = 0; i < 8; i++) check(16'(fs_s[s + i]), 16'(i < 4));
      $display("i2s master test done");
      // AC-Link 16 master with word size and frame length zero
      off();
      wr(`REG_CTRL_TWO, 16'h0000);
      wr(`REG_CTRL_THREE, 16'h0001);
      wr(`REG_CTRL_ONE, 16'h0009);
      cap(560, 1'b0);
      s = first_rise();
      for (int i = 0; i < 256; i++) check(16'(fs_s[s + i]), 16'(i < 16));
      off();
      $display("ac-link master test done");
      // Slave multi-channel on the codec's clock, one 4-bit slot a frame
      wr(`REG_CTRL_THREE, 16'h0000);
      wr(`REG_CTRL_TWO, 16'h0003);
      wr(`REG_CTRL_ONE, 16'h0013);
      check(16'({pin_oe_o[3], pin_oe_o[0]}), 16'h0000);
      run_m <= 1'b1;
      cap(32, 1'b0);
      s = first_rise();
      for (int i = 0; i < 16; i++) begin
         j = i % 8;
         f = (s / 8 + i / 8) % 4;
         if (j < 4) check(16'(sd_s[s + 1 + i]), 16'(words[f][15 - j]));
         else check(16'({oe_s[s + 1 + i], sd_s[s + 1 + i]}), 16'h0002);
      end
      run_m <= 1'b0;
      off();
      $display("slave multi-channel test done");
      report_and_stop();
   end
endmodule // testbench

/* File: tx_shadow_mem.sv */
// Four-word transmit shadow memory with two registered read ports
module tx_shadow_mem (
   input wire logic ref_clk_i,
   input wire logic wr_i,
   input wire logic [1:0] wr_addr_i,
   input wire logic [15:0] wr_data_i,
   input wire logic [1:0] eng_addr_i,
   output logic [15:0] eng_data_o,
   input wire logic [1:0] bus_addr_i,
   output logic [15:0] bus_data_o
);

   logic [15:0] mem_q [4];

   // One write decoder per word
   for (genvar g = 0; g < 4; g++) begin : g_word
      always_ff @(posedge ref_clk_i) begin
         if (wr_i && wr_addr_i == 2'(g)) begin
            mem_q[g] <= wr_data_i;
         end
      end
   end

   // Read data leave through registers
   always_ff @(posedge ref_clk_i) begin
      eng_data_o <= mem_q[eng_addr_i];
      bus_data_o <= mem_q[bus_addr_i];
   end

endmodule // tx_shadow_mem
